// ===== fram_async_sram_port_tb.sv
// Self-checking bench for the F-RAM host port controller.
`timescale 1ns/100ps
module fram_async_sram_port_tb;
  import fsp_pkg::*;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        req = 1'b0;
  logic        req_write = 1'b0;
  logic [18:0] req_addr = 19'h00000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0]  req_be = 2'h3;
  logic        byte_mode = 1'b0;
  logic        ce_hold = 1'b0;
  logic        prot_req = 1'b0;
  logic [7:0]  prot_byte = 8'h00;
  logic        ready, rsp_valid, prot_done, ce_n, we_n, oe_n, ub_n, lb_n, dq_oe;
  logic [15:0] rsp_rdata, dq_o, bus_dq;
  logic [17:0] addr;
  logic [7:0]  prot_bits;
  int          failures = 0;
  int          n_checks = 0;
  ////////////////////////////////////////////////////////////////////
  fsp_host_ctrl dut (.clk(clk), .arst_n(arst_n), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(req_be), .byte_mode(byte_mode), .ce_hold(ce_hold), .prot_req(prot_req),
    .prot_byte(prot_byte), .ready(ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .prot_done(prot_done), .mem_addr(addr), .mem_ce_n(ce_n), .mem_we_n(we_n), .mem_oe_n(oe_n),
    .upper_byte_sel_n(ub_n), .lower_byte_sel_n(lb_n), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(bus_dq));
  fsp_fram_model #(.ACC_NS(100)) model (.mem_addr(addr), .mem_ce_n(ce_n), .mem_we_n(we_n), .mem_oe_n(oe_n),
    .upper_byte_sel_n(ub_n), .lower_byte_sel_n(lb_n), .host_dq(dq_o), .host_dq_oe(dq_oe),
    .bus_dq(bus_dq), .prot_bits(prot_bits));
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Runs one access and checks the fixed answer latency.
  task automatic acc(input logic w, input logic [18:0] a, input logic [15:0] d, input logic [1:0] be,
                     input logic bm, input logic hold);
    @(negedge clk);
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_be = be;
    byte_mode = bm;
    ce_hold = hold;
    @(negedge clk);
    req = 1'b0;
    chk("ready_busy", ready, 1'b0);
    repeat (4) @(negedge clk);
    chk("ce_act", ce_n, 1'b0);
    chk("we_act", we_n, !w);
    chk("oe_act", oe_n, w);
    chk("lb_act", lb_n, bm ? a[18] : !be[0]);
    chk("ub_act", ub_n, bm ? !a[18] : !be[1]);
    repeat (7) @(negedge clk);
    chk("rsp_early", rsp_valid, 1'b0);
    @(negedge clk);
    chk("rsp_valid", rsp_valid, 1'b1);
    chk("ce_end", ce_n, !hold);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("ce_n", ce_n, 1'b1);
    chk("we_n", we_n, 1'b1);
    chk("dq_oe", dq_oe, 1'b0);
    chk("ready", ready, 1'b1);
  endtask
  task automatic t_word();
    acc(1'b1, 19'h01234, 16'ha5c3, 2'h3, 1'b0, 1'b0);
    chk("ce_idle", ce_n, 1'b1);
    acc(1'b0, 19'h01234, 16'h0000, 2'h3, 1'b0, 1'b0);
    chk("word", rsp_rdata, 16'ha5c3);
  endtask
  task automatic t_lanes();
    acc(1'b1, 19'h01234, 16'h1e2f, 2'h1, 1'b0, 1'b0);
    acc(1'b0, 19'h01234, 16'h0000, 2'h3, 1'b0, 1'b0);
    chk("lower", rsp_rdata, 16'ha52f);
    acc(1'b1, 19'h01234, 16'h7700, 2'h2, 1'b0, 1'b0);
    acc(1'b0, 19'h01234, 16'h0000, 2'h3, 1'b0, 1'b0);
    chk("upper", rsp_rdata, 16'h772f);
  endtask
  task automatic t_byte();
    acc(1'b1, 19'h40055, 16'h003c, 2'h3, 1'b1, 1'b0);
    acc(1'b1, 19'h00055, 16'h004d, 2'h3, 1'b1, 1'b0);
    acc(1'b0, 19'h40055, 16'h0000, 2'h3, 1'b1, 1'b0);
    chk("byte_up", rsp_rdata, 16'h003c);
    acc(1'b0, 19'h00055, 16'h0000, 2'h3, 1'b1, 1'b0);
    chk("byte_lo", rsp_rdata, 16'h004d);
    acc(1'b0, 19'h00055, 16'h0000, 2'h3, 1'b0, 1'b0);
    chk("joined", rsp_rdata, 16'h3c4d);
  endtask
  task automatic t_hold();
    acc(1'b0, 19'h00200, 16'h0000, 2'h3, 1'b0, 1'b1);
    chk("ce_held", ce_n, 1'b0);
    acc(1'b0, 19'h00201, 16'h0000, 2'h3, 1'b0, 1'b1);
    chk("held_rd", rsp_rdata, 16'h0201);
    acc(1'b1, 19'h00202, 16'h5a5a, 2'h3, 1'b0, 1'b1);
    acc(1'b0, 19'h00202, 16'h0000, 2'h3, 1'b0, 1'b1);
    chk("held_wr", rsp_rdata, 16'h5a5a);
  endtask
  // Pulls reset in the middle of a read and checks that the strobes fall back to idle.
  task automatic t_reset_mid();
    @(negedge clk);
    req = 1'b1;
    req_write = 1'b0;
    req_addr = 19'h00300;
    req_be = 2'h3;
    byte_mode = 1'b0;
    ce_hold = 1'b0;
    @(negedge clk);
    req = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b0;
    #1;
    chk("ce_rst", ce_n, 1'b1);
    chk("we_rst", we_n, 1'b1);
    chk("oe_rst", oe_n, 1'b1);
    chk("rsp_rst", rsp_valid, 1'b0);
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    acc(1'b0, 19'h00300, 16'h0000, 2'h3, 1'b0, 1'b0);
    chk("rd_after_rst", rsp_rdata, 16'h0300);
  endtask
  task automatic t_prot();
    int n;
    n = 0;
    @(negedge clk);
    prot_req = 1'b1;
    prot_byte = 8'h01;
    @(negedge clk);
    prot_req = 1'b0;
    while (prot_done !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("prot_done", prot_done, 1'b1);
    chk("prot_bits", prot_bits, 8'h01);
    acc(1'b1, 19'h00010, 16'hbeef, 2'h3, 1'b0, 1'b0);
    acc(1'b0, 19'h00010, 16'h0000, 2'h3, 1'b0, 1'b0);
    chk("prot_sec", rsp_rdata, 16'h0010);
    acc(1'b1, 19'h08010, 16'hbeef, 2'h3, 1'b0, 1'b0);
    acc(1'b0, 19'h08010, 16'h0000, 2'h3, 1'b0, 1'b0);
    chk("open_sec", rsp_rdata, 16'hbeef);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_word();
    t_lanes();
    t_byte();
    t_reset_mid();
    t_hold();
    t_prot();
    print_verdict();
  end
endmodule

// ===== fsp_fram_model.sv
// Behavioural F-RAM device model answering the host port pins.
`timescale 1ns/100ps
module fsp_fram_model
  import fsp_pkg::*;
#(
  parameter int ACC_NS = 0
)(
  input  wire logic [17:0] mem_addr,
  input  wire logic        mem_ce_n,
  input  wire logic        mem_we_n,
  input  wire logic        mem_oe_n,
  input  wire logic        upper_byte_sel_n,
  input  wire logic        lower_byte_sel_n,
  input  wire logic [15:0] host_dq,
  input  wire logic        host_dq_oe,
  output logic [15:0]      bus_dq,
  output logic [7:0]       prot_bits
);
  localparam logic [17:0] SEQ [9] = '{18'h24555, 18'h3aaaa, 18'h02333, 18'h1cccc, 18'h000ff,
                                      18'h3ef00, 18'h3aaaa, 18'h1cccc, 18'h0ff00};
  logic [15:0] mem [0:262143];
  logic [15:0] rd_d;
  logic [3:0]  st;
  logic [7:0]  pend;
  logic [7:0]  wd;
  logic        wr;
  logic        rd_en;
  ////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 262144; i++) begin
      mem[i] = i[15:0];
    end
    st = 4'h0;
    pend = 8'h00;
    wd = 8'h00;
    wr = 1'b0;
    prot_bits = 8'h00;
  end
  // Any address change while selected reaches the array, so no select toggle is needed.
  assign #(ACC_NS) rd_d = mem[mem_addr];
  assign rd_en = !mem_ce_n && !mem_oe_n && mem_we_n;
  // Each byte select gates its own lane; an undriven lane shows the inverse of the stored byte.
  always_comb begin
    bus_dq = ~rd_d;
    if (host_dq_oe) begin
      bus_dq = host_dq;
    end else begin
      if (rd_en && !lower_byte_sel_n) bus_dq[7:0] = rd_d[7:0];
      if (rd_en && !upper_byte_sel_n) bus_dq[15:8] = rd_d[15:8];
    end
  end
  always @(negedge mem_we_n) wr = 1'b1;
  // Writes land lane by lane unless the sector is protected or the tracker holds them.
  always @(posedge mem_we_n) begin
    wd = bus_dq[7:0];
    if (!mem_ce_n && st < 4'h6 && !prot_bits[mem_addr[17:15]]) begin
      if (!lower_byte_sel_n) mem[mem_addr][7:0] = bus_dq[7:0];
      if (!upper_byte_sel_n) mem[mem_addr][15:8] = bus_dq[15:8];
    end
  end
  // The tracker steps on each rise of chip select and starts over on any deviation.
  always @(posedge mem_ce_n) begin
    if (mem_addr == SEQ[st] && wr == (st > 4'h5) && (st != 4'h7 || wd == ~pend)) begin
      if (st == 4'h6) pend = wd;
      if (st == 4'h7) prot_bits = pend;
      st = (st == 4'h8) ? 4'h0 : st + 4'h1;
    end else begin
      st = (!wr && mem_addr == SEQ[0]) ? 4'h1 : 4'h0;
    end
    wr = 1'b0;
  end
endmodule

// ===== fsp_host_ctrl.sv
// Host-side controller driving the asynchronous SRAM-style pins of an F-RAM.
// Device behaviour and the rules this block is written to
// R1: During the protection sequence each address is set up at least 10 ns before chip select falls and held while it is low.
// R2: The device needs no chip select toggle between accesses, so chip select may be held low with only the address changing.
// R3: The device sustains page-mode column accesses up to 40 MHz while chip select stays low.
// R4: Chip select is actively driven, since a grounded chip select cannot run the protection sequence.
// R5: The write strobe stays high whenever chip select is low outside a write, including through reset and power cycles.
// R6: The device draws active current while chip select is low, so chip select is released when idle unless holding is asked for.
// R7: The device accepts chip select pulsed low for every single access.
// R8: Each byte select gates its own data lane for both reads and writes.
// R9: In byte mode the lanes are joined and the extra high address bit picks the lane, giving a 512K x 8 memory.
// R10: Protection is changed by six fixed reads, writes of the byte, its complement and a dummy, then a read of 00000h.
// R11: The protection byte sits on the low data lane, bit n protecting sector n, and is kept nonvolatile by the device.
// R12: The device restarts its tracker on any out-of-order step, and the sequence reads still return array data.
// R13: If chip select is already low when the sequence begins, an access to 00000h comes first.
`timescale 1ns/100ps
module fsp_host_ctrl
  import fsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic [18:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic [1:0]  req_be,
  input  wire logic        byte_mode,
  input  wire logic        ce_hold,
  input  wire logic        prot_req,
  input  wire logic [7:0]  prot_byte,
  output logic             ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             prot_done,
  output logic [17:0]      mem_addr,
  output logic             mem_ce_n,
  output logic             mem_we_n,
  output logic             mem_oe_n,
  output logic             upper_byte_sel_n,
  output logic             lower_byte_sel_n,
  output logic [15:0]      mem_dq_o,
  output logic             mem_dq_oe,
  input  wire logic [15:0] mem_dq_i
);

  fsp_state_type state_ff, nxt_state;
  logic [3:0]  cnt_ff, nxt_cnt, idx_ff, nxt_idx;
  logic [17:0] addr_ff, step_addr;
  logic [15:0] wdata_ff, rdata_ff, dq_s1_ff, dq_s2_ff;
  logic [7:0]  pbyte_ff;
  logic [1:0]  lane_ff, step_kind;
  logic        wr_ff, prot_ff, bm_ff, hi_ff, hold_ff;
  logic        ce_n_ff, we_n_ff, oe_n_ff, ub_n_ff, lb_n_ff, dq_oe_ff;
  logic        rsp_ff, done_ff, step_write;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence table and decode.

  fsp_prot_seq_rom u_rom (
    .clk           (clk),
    .arst_n        (arst_n),
    .idx           (nxt_idx),
    .step_addr_ff  (step_addr),
    .step_write_ff (step_write),
    .step_kind_ff  (step_kind)
  );

  wire cnt_done     = (cnt_ff == CNT_ZERO);
  wire take_prot    = (state_ff == ST_IDLE) && prot_req;
  wire take_req     = (state_ff == ST_IDLE) && !prot_req && req;
  wire seq_end      = (state_ff == ST_RECOVER) && cnt_done;
  wire prot_last    = (idx_ff == PROT_IDX_LAST);
  wire nxt_busy     = (nxt_state == ST_SETUP) || (nxt_state == ST_ACTIVE);
  wire hold_low     = hold_ff && !prot_ff && (nxt_state != ST_LOAD);
  wire [7:0] lane_rd = hi_ff ? dq_s2_ff[15:8] : dq_s2_ff[7:0];
  wire [7:0] step_lo = (step_kind == KIND_BYTE) ? prot_byte :
                       (step_kind == KIND_CPL)  ? ~pbyte_ff : 8'h00;

  assign ready = (state_ff == ST_IDLE) && !prot_req;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = (cnt_ff == CNT_ZERO) ? CNT_ZERO : cnt_ff - CNT_ONE;
    nxt_idx   = idx_ff;
    case (state_ff)
      ST_IDLE: begin
        if (prot_req) begin
          nxt_state = ST_LOAD;
          nxt_idx   = ce_n_ff ? PROT_IDX_FIRST : PROT_IDX_PRE; // [R13]
        end else if (req) begin
          nxt_state = ST_SETUP;
          nxt_cnt   = SETUP_CYC - CNT_ONE;
        end
      end
      ST_LOAD: begin
        nxt_state = ST_SETUP;
        nxt_cnt   = SETUP_CYC - CNT_ONE; // [R1]
      end
      ST_SETUP: begin
        if (cnt_done) begin
          nxt_state = ST_ACTIVE;
          nxt_cnt   = ACTIVE_CYC - CNT_ONE;
        end
      end
      ST_ACTIVE: begin
        if (cnt_done) begin
          nxt_state = ST_RECOVER;
          nxt_cnt   = PC_CYC - CNT_ONE;
        end
      end
      ST_RECOVER: begin
        if (cnt_done) begin
          if (prot_ff && !prot_last) begin
            nxt_state = ST_LOAD;
            nxt_idx   = idx_ff + CNT_ONE; // [R10]
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= CNT_ZERO;
      idx_ff   <= PROT_IDX_PRE;
      dq_s1_ff <= 16'h0000;
      dq_s2_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      idx_ff   <= nxt_idx;
      dq_s1_ff <= mem_dq_i;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-access context, loaded only while chip select is high or on entry.

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff  <= 18'h00000;
      wdata_ff <= 16'h0000;
      wr_ff    <= 1'b0;
      lane_ff  <= 2'h0;
      prot_ff  <= 1'b0;
      bm_ff    <= 1'b0;
      hi_ff    <= 1'b0;
      hold_ff  <= 1'b0;
      pbyte_ff <= 8'h00;
    end else if (take_prot) begin
      prot_ff  <= 1'b1;
      bm_ff    <= byte_mode;
      hi_ff    <= 1'b0;
      hold_ff  <= 1'b0; // [R4]
      pbyte_ff <= prot_byte;
    end else if (take_req) begin
      addr_ff  <= req_addr[17:0];
      wr_ff    <= req_write;
      bm_ff    <= byte_mode;
      hi_ff    <= byte_mode && req_addr[18]; // [R9]
      hold_ff  <= ce_hold; // [R2]
      lane_ff  <= byte_mode ? {req_addr[18], !req_addr[18]} : req_be; // [R8] [R9]
      wdata_ff <= byte_mode ? {req_wdata[7:0], req_wdata[7:0]} : req_wdata; // [R9]
    end else if (state_ff == ST_LOAD) begin
      addr_ff  <= step_addr; // [R10]
      wr_ff    <= step_write;
      lane_ff  <= {!bm_ff, 1'b1};
      wdata_ff <= {8'h00, step_lo}; // [R11]
    end else if (seq_end && (!prot_ff || prot_last)) begin
      prot_ff  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin drive and user answers.

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ce_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      ub_n_ff  <= 1'b1;
      lb_n_ff  <= 1'b1;
      dq_oe_ff <= 1'b0;
      rsp_ff   <= 1'b0;
      done_ff  <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      ce_n_ff  <= !((nxt_state == ST_ACTIVE) || hold_low); // [R6] [R7]
      we_n_ff  <= !((nxt_state == ST_ACTIVE) && wr_ff && (nxt_cnt != CNT_ZERO)); // [R5]
      oe_n_ff  <= !((nxt_state == ST_ACTIVE) && !wr_ff);
      ub_n_ff  <= !(nxt_busy && lane_ff[1]); // [R8]
      lb_n_ff  <= !(nxt_busy && lane_ff[0]); // [R8]
      dq_oe_ff <= (nxt_state == ST_ACTIVE) && wr_ff;
      rsp_ff   <= seq_end && !prot_ff;
      done_ff  <= seq_end && prot_ff && prot_last;
      if ((state_ff == ST_ACTIVE) && cnt_done && !wr_ff && !prot_ff) begin
        rdata_ff <= bm_ff ? {8'h00, lane_rd} : dq_s2_ff; // [R9]
      end
    end
  end

  assign mem_addr         = addr_ff;
  assign mem_ce_n         = ce_n_ff;
  assign mem_we_n         = we_n_ff;
  assign mem_oe_n         = oe_n_ff;
  assign upper_byte_sel_n = ub_n_ff;
  assign lower_byte_sel_n = lb_n_ff;
  assign mem_dq_o         = wdata_ff;
  assign mem_dq_oe        = dq_oe_ff;
  assign rsp_valid        = rsp_ff;
  assign rsp_rdata        = rdata_ff;
  assign prot_done        = done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_prot_addr_stable;
    prot_ff && !mem_ce_n |-> $stable(mem_addr);
  endproperty
  a_prot_addr_stable: assert property (p_prot_addr_stable) else $error("address moved under chip select"); // [R1]

  property p_prot_setup;
    prot_ff && $fell(mem_ce_n) |-> $past(mem_addr) == mem_addr && $past(mem_ce_n, 2);
  endproperty
  a_prot_setup: assert property (p_prot_setup) else $error("address setup too short"); // [R1]

  property p_hold_low;
    hold_ff && !prot_ff && (state_ff == ST_RECOVER) |-> !mem_ce_n;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("held chip select released"); // [R2]

  property p_prot_toggle;
    prot_ff && (state_ff == ST_LOAD) |-> mem_ce_n;
  endproperty
  a_prot_toggle: assert property (p_prot_toggle) else $error("chip select not toggled in sequence"); // [R4]

  property p_we_needs_ce;
    !mem_we_n |-> !mem_ce_n && mem_oe_n && mem_dq_oe;
  endproperty
  a_we_needs_ce: assert property (p_we_needs_ce) else $error("write strobe without chip select"); // [R5]

  property p_we_pulse;
    $fell(mem_we_n) |-> (!mem_we_n)[*7] ##1 (mem_we_n && !mem_ce_n) ##1 (mem_ce_n != hold_ff);
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse length wrong"); // [R7]

  property p_byte_lane;
    bm_ff && !prot_ff && !mem_ce_n |-> upper_byte_sel_n != lower_byte_sel_n;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte mode lane select wrong"); // [R9]

  property p_cpl_data;
    prot_ff && (idx_ff == PROT_IDX_CPL) && mem_dq_oe |-> mem_dq_o[7:0] == ~pbyte_ff;
  endproperty
  a_cpl_data: assert property (p_cpl_data) else $error("complement byte wrong"); // [R11]

  property p_pre_access;
    take_prot && !mem_ce_n |=> idx_ff == PROT_IDX_PRE;
  endproperty
  a_pre_access: assert property (p_pre_access) else $error("missing leading zero access"); // [R13]

  property p_step_order;
    prot_ff && seq_end && !prot_last |=> idx_ff == $past(idx_ff) + CNT_ONE;
  endproperty
  a_step_order: assert property (p_step_order) else $error("protection step skipped"); // [R10]

  c_prot_done: cover property (prot_done);
  c_byte_read: cover property (rsp_valid && bm_ff && !wr_ff);
  c_held_write: cover property (hold_ff && !mem_we_n);
  c_pre_access: cover property (take_prot && !mem_ce_n);

endmodule

// ===== fsp_pkg.sv
// Shared constants and types for the F-RAM host port controller.
package fsp_pkg;

  localparam int CLK_PERIOD_NS   = 20;
  localparam int T_PROT_SETUP_NS = 10;
  localparam int T_ACCESS_NS     = 110;
  localparam int T_PRECHARGE_NS  = 55;
  localparam int SYNC_STAGES     = 2;

  localparam int SETUP_RAW = (T_PROT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_RAW   = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PC_RAW    = (T_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] SETUP_CYC  = 4'((SETUP_RAW < 1) ? 1 : SETUP_RAW);
  localparam logic [3:0] ACTIVE_CYC = 4'(ACC_RAW + SYNC_STAGES);
  localparam logic [3:0] PC_CYC     = 4'((PC_RAW < 1) ? 1 : PC_RAW);
  localparam logic [3:0] CNT_ZERO   = 4'h0;
  localparam logic [3:0] CNT_ONE    = 4'h1;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;

  localparam logic [3:0] PROT_IDX_PRE   = 4'h0;
  localparam logic [3:0] PROT_IDX_FIRST = 4'h1;
  localparam logic [3:0] PROT_IDX_CPL   = 4'h8;
  localparam logic [3:0] PROT_IDX_LAST  = 4'ha;

  localparam logic [17:0] PROT_A_ZERO = 18'h00000;
  localparam logic [17:0] PROT_A_1    = 18'h24555;
  localparam logic [17:0] PROT_A_2    = 18'h3aaaa;
  localparam logic [17:0] PROT_A_3    = 18'h02333;
  localparam logic [17:0] PROT_A_4    = 18'h1cccc;
  localparam logic [17:0] PROT_A_5    = 18'h000ff;
  localparam logic [17:0] PROT_A_6    = 18'h3ef00;
  localparam logic [17:0] PROT_A_9    = 18'h0ff00;

  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_BYTE = 2'h1;
  localparam logic [1:0] KIND_CPL  = 2'h2;
  localparam logic [1:0] KIND_ANY  = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_LOAD    = 6'h02,
    ST_SETUP   = 6'h04,
    ST_ACTIVE  = 6'h08,
    ST_RECOVER = 6'h10,
    ST_SPARE   = 6'h20
  } fsp_state_type;

endpackage

// ===== fsp_prot_seq_rom.sv
// Step table of the protection-setting sequence with a registered read port.
`timescale 1ns/100ps
module fsp_prot_seq_rom
  import fsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  idx,
  output logic [17:0]      step_addr_ff,
  output logic             step_write_ff,
  output logic [1:0]       step_kind_ff
);

  logic [17:0] tab_addr;
  logic        tab_write;
  logic [1:0]  tab_kind;

  // Reads, then the three writes, then the closing read of the sequence. [R10]
  always_comb begin
    tab_write = 1'b0;
    tab_kind  = KIND_NONE;
    case (idx)
      4'h1: tab_addr = PROT_A_1;
      4'h2: tab_addr = PROT_A_2;
      4'h3: tab_addr = PROT_A_3;
      4'h4: tab_addr = PROT_A_4;
      4'h5: tab_addr = PROT_A_5;
      4'h6: tab_addr = PROT_A_6;
      4'h7: begin
        tab_addr  = PROT_A_2;
        tab_write = 1'b1;
        tab_kind  = KIND_BYTE;
      end
      4'h8: begin
        tab_addr  = PROT_A_4;
        tab_write = 1'b1;
        tab_kind  = KIND_CPL;
      end
      4'h9: begin
        tab_addr  = PROT_A_9;
        tab_write = 1'b1;
        tab_kind  = KIND_ANY;
      end
      default: tab_addr = PROT_A_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step_addr_ff  <= PROT_A_ZERO;
      step_write_ff <= 1'b0;
      step_kind_ff  <= KIND_NONE;
    end else begin
      step_addr_ff  <= tab_addr;
      step_write_ff <= tab_write;
      step_kind_ff  <= tab_kind;
    end
  end

endmodule
